// file: logic/lou_top.sv
// Logic-operation unit of an 8-bit core, reached over classic Wishbone.
// Assumes one clock; memory and IO writes leave as one-cycle strobes.
//
// Behaviour
// - AND with immediate writes work register, updates zero only.
// - AND with memory byte goes to work register or memory; zero only.
// - OR with immediate writes work register, other three flags held.
// - OR with memory byte goes to work register or memory; zero only.
// - XOR with immediate writes work register, updates zero only.
// - XOR into an IO register writes back there and changes no flag.
// - XOR with memory byte goes to work register or memory; zero only.
// - Invert work register bitwise, updates zero only.
// - Invert a memory byte and write it back, updates zero only.
// - Negate work register as inverse plus one, updates zero only.
// - Negate a memory byte and write it back, updates zero only.
`timescale 1ns/1ps
`default_nettype none
`include "lou_regs.svh"

module lou_top
  import lou_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Result write-back
  output logic             mem_wr_o,
  output logic      [7:0]  mem_wdata_o,
  output logic             io_wr_o,
  output logic      [7:0]  io_wdata_o,
  // Core state
  output logic      [7:0]  work_o,
  output logic      [3:0]  flags_o
);
  import lou_pkg::*;

  lou_if     bus ();
  lou_core_s s;
  lou_core_s next_s;
  logic      exec;
  lou_op_e   exec_op;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr == off);
  endfunction

  function automatic logic op_legal(input logic [3:0] code);
    op_legal = (code <= LOU_OP_NEG_M);
  endfunction

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  assign bus.cyc = wb_cyc_i;
  assign bus.stb = wb_stb_i;
  assign bus.we  = wb_we_i;
  assign bus.op  = exec_op;
  assign bus.a   = s.work;
  assign bus.b   = s.opnd;

  lou_dec u_dec (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (bus.dec_mp)
  );

  lou_alu u_alu (
    .bus (bus.alu_mp)
  );

  // Illegal codes are dropped whole so no flag moves on a bad write
  assign exec_op = lou_op_e'(wb_dat_i[3:0]);
  assign exec    = bus.wr_commit && wb_sel_i[0] && reg_hit(wb_adr_i, `LOU_OFF_CMD)
                   && op_legal(wb_dat_i[3:0]);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s        = s;
    next_s.mem_wr = 1'b0;
    next_s.io_wr  = 1'b0;
    if (bus.rd_start)
    begin
      next_s.rdata = 32'h0000_0000;
      if (reg_hit(wb_adr_i, `LOU_OFF_WORK))
        next_s.rdata = {24'h00_0000, s.work};
      else if (reg_hit(wb_adr_i, `LOU_OFF_FLAGS))
        next_s.rdata = {28'h000_0000, s.flags};
      else if (reg_hit(wb_adr_i, `LOU_OFF_OPND))
        next_s.rdata = {24'h00_0000, s.opnd};
      else if (reg_hit(wb_adr_i, `LOU_OFF_CMD))
        next_s.rdata = {28'h000_0000, s.last_op};
      else if (reg_hit(wb_adr_i, `LOU_OFF_RESULT))
        next_s.rdata = {22'h0_0000, s.result};
    end
    if (bus.wr_commit && wb_sel_i[0])
    begin
      if (reg_hit(wb_adr_i, `LOU_OFF_WORK))
        next_s.work = wb_dat_i[7:0];
      if (reg_hit(wb_adr_i, `LOU_OFF_FLAGS))
        next_s.flags = wb_dat_i[3:0];
      if (reg_hit(wb_adr_i, `LOU_OFF_OPND))
        next_s.opnd = wb_dat_i[7:0];
    end
    if (exec)
    begin
      next_s.last_op = wb_dat_i[3:0];
      next_s.wdata   = bus.res;
      next_s.result  = {bus.dst == LOU_DST_IO, bus.dst == LOU_DST_MEM, bus.res};
      unique case (bus.dst)
        LOU_DST_WORK: next_s.work   = bus.res;
        LOU_DST_MEM:  next_s.mem_wr = 1'b1;
        LOU_DST_IO:   next_s.io_wr  = 1'b1;
        default:      next_s.wdata  = bus.res;
      endcase
      // Borrow, nibble-borrow and signed-range bits are never touched here
      if (bus.upd_zero)
        next_s.flags[`LOU_FLAG_ZERO] = (bus.res == 8'h00);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s        <= '0;
      s.work   <= `LOU_RST_WORK;
      s.flags  <= `LOU_RST_FLAGS;
      s.opnd   <= `LOU_RST_OPND;
      s.result <= `LOU_RST_RESULT;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o    = s.rdata;
  assign wb_ack_o    = bus.ack;
  assign mem_wr_o    = s.mem_wr;
  assign mem_wdata_o = s.wdata;
  assign io_wr_o     = s.io_wr;
  assign io_wdata_o  = s.wdata;
  assign work_o      = s.work;
  assign flags_o     = s.flags;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_and_imm_work: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_AND_IMM
    |=> s.work == ($past(s.work) & $past(s.opnd))
        && s.flags[3:1] == $past(s.flags[3:1]) && !s.mem_wr)
    else $error("and immediate result or flags wrong");

  a_and_mem_dest: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_AND_MEM_M
    |=> s.mem_wr && mem_wdata_o == ($past(s.work) & $past(s.opnd))
        && $stable(s.work) ##1 !s.mem_wr)
    else $error("and to memory not written once");

  a_or_imm_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_OR_IMM
    |=> s.work == ($past(s.work) | $past(s.opnd))
        && $stable(s.flags[`LOU_FLAG_SRANGE:`LOU_FLAG_BORROW]))
    else $error("or immediate result or held flags wrong");

  a_or_mem_work: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op inside {LOU_OP_OR_MEM_A, LOU_OP_OR_MEM_M}
    |=> (s.mem_wr ? $stable(s.work) : s.work == ($past(s.work) | $past(s.opnd)))
        && s.wdata == ($past(s.work) | $past(s.opnd)) && !s.io_wr)
    else $error("or with memory byte wrong");

  a_xor_imm_work: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_XOR_IMM
    |=> s.work == ($past(s.work) ^ $past(s.opnd)) && !s.mem_wr && !s.io_wr)
    else $error("xor immediate result wrong");

  a_xor_io_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_XOR_IO
    |=> io_wr_o && io_wdata_o == ($past(s.work) ^ $past(s.opnd))
        && $stable(s.flags) && $stable(s.work))
    else $error("xor to io register wrong or flags moved");

  a_xor_mem_dest: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_XOR_MEM_A
    |=> s.work == ($past(s.work) ^ $past(s.opnd)) && !s.mem_wr
        && $stable(s.flags[3:1]))
    else $error("xor memory into work register wrong");

  a_not_work_inv: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_NOT_A
    |=> s.work == ~$past(s.work) && $stable(s.flags[3:1]))
    else $error("invert of work register wrong");

  a_not_mem_back: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_NOT_M
    |=> s.mem_wr && mem_wdata_o == ~$past(s.opnd) && $stable(s.work))
    else $error("invert of memory byte wrong");

  a_neg_work_val: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_NEG_A
    |=> 8'(s.work + $past(s.work)) == 8'h00 && $stable(s.flags[3:1]))
    else $error("negate of work register wrong");

  a_neg_mem_back: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_NEG_M
    |=> s.mem_wr && 8'(mem_wdata_o + $past(s.opnd)) == 8'h00 && $stable(s.work))
    else $error("negate of memory byte wrong");

  a_zero_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op != LOU_OP_XOR_IO
    |=> s.flags[`LOU_FLAG_ZERO] == (s.result[7:0] == 8'h00))
    else $error("zero flag does not match result");

  a_and_mem_work: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_AND_MEM_A
    |=> s.work == ($past(s.work) & $past(s.opnd)) && !s.mem_wr
        && $stable(s.flags[3:1]))
    else $error("and memory into work register wrong");

  a_and_mem_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_AND_MEM_M
    |=> $stable(s.flags[3:1]) && !s.io_wr)
    else $error("and to memory moved a held flag");

  a_or_mem_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op inside {LOU_OP_OR_MEM_A, LOU_OP_OR_MEM_M}
    |=> $stable(s.flags[3:1]))
    else $error("or with memory byte moved a held flag");

  a_xor_imm_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_XOR_IMM
    |=> $stable(s.flags[3:1]))
    else $error("xor immediate moved a held flag");

  a_xor_mem_back: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_XOR_MEM_M
    |=> s.mem_wr && mem_wdata_o == ($past(s.work) ^ $past(s.opnd))
        && $stable(s.work) && $stable(s.flags[3:1]))
    else $error("xor to memory wrong");

  a_not_mem_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_NOT_M
    |=> $stable(s.flags[3:1]) && !s.io_wr)
    else $error("invert of memory byte moved a held flag");

  a_neg_mem_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_NEG_M
    |=> $stable(s.flags[3:1]) && !s.io_wr)
    else $error("negate of memory byte moved a held flag");

  a_not_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_NOT_A
    |=> s.flags[`LOU_FLAG_ZERO] == ($past(s.work) == 8'hFF))
    else $error("zero flag wrong after invert");

  a_neg_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_NEG_A
    |=> s.flags[`LOU_FLAG_ZERO] == ($past(s.work) == 8'h00))
    else $error("zero flag wrong after negate");

  // ----------------------------------------------------------------------
  // Write-back strobes and refused codes
  // ----------------------------------------------------------------------
  a_mem_strobe_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_wr_o |=> !mem_wr_o)
    else $error("memory write strobe longer than one cycle");

  a_io_strobe_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    io_wr_o |=> !io_wr_o)
    else $error("io write strobe longer than one cycle");

  a_xor_io_result: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && exec_op == LOU_OP_XOR_IO
    |=> !s.mem_wr && s.result[`LOU_RES_IO_BIT] && !s.result[`LOU_RES_MEM_BIT])
    else $error("xor to io register marked or sent wrong");

  a_strobe_needs_op: assert property (@(posedge clk_i) disable iff (rst_i)
    !exec |=> !s.mem_wr && !s.io_wr)
    else $error("write-back strobe without an operation");

  // A refused code must leave no trace, not even a flag
  a_bad_code_held: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.wr_commit && wb_sel_i[0] && reg_hit(wb_adr_i, `LOU_OFF_CMD) && !op_legal(wb_dat_i[3:0])
    |=> $stable(s.work) && $stable(s.flags) && !s.mem_wr && !s.io_wr)
    else $error("refused operation code changed state");

endmodule

`default_nettype wire

// file: logic/lou_regs.svh
// Register offsets, field positions and reset values of the logic unit.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef LOU_REGS_SVH
`define LOU_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LOU_ADDR_W      8
`define LOU_OFF_WORK    8'h00
`define LOU_OFF_FLAGS   8'h04
`define LOU_OFF_OPND    8'h08
`define LOU_OFF_CMD     8'h0C
`define LOU_OFF_RESULT  8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LOU_FLAG_ZERO   0
`define LOU_FLAG_BORROW 1
`define LOU_FLAG_NIBBLE 2
`define LOU_FLAG_SRANGE 3
`define LOU_RES_MEM_BIT 8
`define LOU_RES_IO_BIT  9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LOU_RST_WORK    8'h00
`define LOU_RST_FLAGS   4'h0
`define LOU_RST_OPND    8'h00
`define LOU_RST_RESULT  10'h000

`endif

// file: logic/lou_pkg.sv
// Types shared by the logic unit modules.
// Assumes nothing beyond a SystemVerilog compiler.
package lou_pkg;

  // ----------------------------------------------------------------------
  // Operation codes, in the order software writes them
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    LOU_OP_AND_IMM,
    LOU_OP_AND_MEM_A,
    LOU_OP_AND_MEM_M,
    LOU_OP_OR_IMM,
    LOU_OP_OR_MEM_A,
    LOU_OP_OR_MEM_M,
    LOU_OP_XOR_IMM,
    LOU_OP_XOR_IO,
    LOU_OP_XOR_MEM_A,
    LOU_OP_XOR_MEM_M,
    LOU_OP_NOT_A,
    LOU_OP_NOT_M,
    LOU_OP_NEG_A,
    LOU_OP_NEG_M
  } lou_op_e;

  // ----------------------------------------------------------------------
  // Result destinations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LOU_DST_WORK,
    LOU_DST_MEM,
    LOU_DST_IO
  } lou_dst_e;

  // ----------------------------------------------------------------------
  // Module state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic ack;
  } lou_dec_s;

  typedef struct packed {
    logic [7:0]  work;
    logic [3:0]  flags;
    logic [7:0]  opnd;
    logic [3:0]  last_op;
    logic [9:0]  result;
    logic [31:0] rdata;
    logic        mem_wr;
    logic        io_wr;
    logic [7:0]  wdata;
  } lou_core_s;

endpackage

// file: logic/lou_if.sv
// Carrier between the core, the operation unit and the bus decoder.
// Assumes the core drives the bus request copies and the operands.
`timescale 1ns/1ps
`default_nettype none

interface lou_if;
  import lou_pkg::*;

  // Operation group
  lou_op_e     op;
  logic [7:0]  a;
  logic [7:0]  b;
  logic [7:0]  res;
  lou_dst_e    dst;
  logic        upd_zero;
  // Bus access group
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        rd_start;
  logic        wr_commit;

  modport alu_mp  (input op, a, b, output res, dst, upd_zero);
  modport dec_mp  (input cyc, stb, we, output ack, rd_start, wr_commit);
  modport core_mp (output op, a, b, cyc, stb, we,
                   input res, dst, upd_zero, ack, rd_start, wr_commit);
endinterface

`default_nettype wire

// file: logic/lou_alu.sv
// Operation unit: result, destination and zero-update of one operation.
// Assumes operands are stable for the cycle in which the core commits.
`timescale 1ns/1ps
`default_nettype none

module lou_alu
  import lou_pkg::*;
(
  // Operation carrier
  lou_if.alu_mp bus
);

  // ----------------------------------------------------------------------
  // Combine operands
  // ----------------------------------------------------------------------
  always_comb
  begin
    bus.res      = 8'h00;
    bus.dst      = LOU_DST_WORK;
    bus.upd_zero = 1'b1;
    unique case (bus.op)
      LOU_OP_AND_IMM,
      LOU_OP_AND_MEM_A:  bus.res = bus.a & bus.b;
      LOU_OP_AND_MEM_M:
      begin
        bus.res = bus.a & bus.b;
        bus.dst = LOU_DST_MEM;
      end
      LOU_OP_OR_IMM,
      LOU_OP_OR_MEM_A:   bus.res = bus.a | bus.b;
      LOU_OP_OR_MEM_M:
      begin
        bus.res = bus.a | bus.b;
        bus.dst = LOU_DST_MEM;
      end
      LOU_OP_XOR_IMM,
      LOU_OP_XOR_MEM_A:  bus.res = bus.a ^ bus.b;
      LOU_OP_XOR_IO:
      begin
        bus.res      = bus.a ^ bus.b;
        bus.dst      = LOU_DST_IO;
        bus.upd_zero = 1'b0;
      end
      LOU_OP_XOR_MEM_M:
      begin
        bus.res = bus.a ^ bus.b;
        bus.dst = LOU_DST_MEM;
      end
      LOU_OP_NOT_A:      bus.res = ~bus.a;
      LOU_OP_NOT_M:
      begin
        bus.res = ~bus.b;
        bus.dst = LOU_DST_MEM;
      end
      LOU_OP_NEG_A:      bus.res = ~bus.a + 8'h01;
      LOU_OP_NEG_M:
      begin
        bus.res = ~bus.b + 8'h01;
        bus.dst = LOU_DST_MEM;
      end
      default:           bus.upd_zero = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// file: logic/lou_dec.sv
// Classic Wishbone handshake: one wait state, ack high for one cycle.
// Assumes the master holds its request until it samples ack.
`timescale 1ns/1ps
`default_nettype none

module lou_dec
  import lou_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Bus carrier
  lou_if.dec_mp     bus
);

  lou_dec_s s;
  lou_dec_s next_s;

  // ----------------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s     = s;
    next_s.ack = bus.cyc && bus.stb && !s.ack;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  // Writes commit on the edge the master samples ack
  assign bus.ack       = s.ack;
  assign bus.rd_start  = bus.cyc && bus.stb && !s.ack;
  assign bus.wr_commit = bus.cyc && bus.stb && s.ack && bus.we;

  a_ack_single_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    s.ack |=> !s.ack)
    else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

// file: verification/logic_op_unit_bench.sv
// Self-checking bench of the logic-operation unit, driven over Wishbone.
// Assumes lou_pkg, lou_regs.svh and lou_top are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
`include "lou_regs.svh"

`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module logic_op_unit_bench;
  import lou_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  typedef struct {
    logic [3:0] op;
    logic [7:0] work;
    logic [7:0] opnd;
    logic [3:0] flg;
    logic [7:0] res;
  } lou_row_s;

  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic        io_wr_o;
  logic [7:0]  io_wdata_o;
  logic [7:0]  work_o;
  logic [3:0]  flags_o;
  int          errors    = 0;
  int          cmp_count = 0;
  int          cycles    = 0;
  logic [31:0] q;
  logic        st_mem;
  logic        st_io;
  logic [7:0]  st_wd;
  logic [7:0]  st_iod;
  logic [1:0]  k;
  logic [7:0]  exp_w;
  logic [3:0]  exp_f;

  // Zero-result rows are mixed in among nonzero ones so the zero bit moves both ways
  lou_row_s rows [18] = '{
    '{4'h0, 8'h3C, 8'h0F, 4'hF, 8'h0C}, '{4'h1, 8'hF0, 8'h0F, 4'hE, 8'h00},
    '{4'h2, 8'hA5, 8'hFF, 4'h1, 8'hA5}, '{4'h3, 8'h30, 8'h0F, 4'hF, 8'h3F},
    '{4'h4, 8'h00, 8'h00, 4'h6, 8'h00}, '{4'h5, 8'h81, 8'h18, 4'h9, 8'h99},
    '{4'h6, 8'hFF, 8'hFF, 4'hA, 8'h00}, '{4'h7, 8'h55, 8'h0F, 4'h5, 8'h5A},
    '{4'h7, 8'hAA, 8'hAA, 4'hE, 8'h00}, '{4'h8, 8'h12, 8'h34, 4'hF, 8'h26},
    '{4'h9, 8'h5A, 8'h5A, 4'hE, 8'h00}, '{4'hA, 8'h38, 8'h00, 4'h1, 8'hC7},
    '{4'hA, 8'hFF, 8'h00, 4'hE, 8'h00}, '{4'hB, 8'h00, 8'h38, 4'hF, 8'hC7},
    '{4'hC, 8'h38, 8'h00, 4'h1, 8'hC8}, '{4'hC, 8'h00, 8'h00, 4'h6, 8'h00},
    '{4'hD, 8'h00, 8'h38, 4'h9, 8'hC8}, '{4'hD, 8'h55, 8'h80, 4'h0, 8'h80}
  };
  logic [7:0] offs [4] = '{`LOU_OFF_WORK, `LOU_OFF_FLAGS, `LOU_OFF_OPND, `LOU_OFF_RESULT};

  lou_top u_dut (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wb_cyc_i    (wb_cyc_i),
    .wb_stb_i    (wb_stb_i),
    .wb_we_i     (wb_we_i),
    .wb_adr_i    (wb_adr_i),
    .wb_sel_i    (wb_sel_i),
    .wb_dat_i    (wb_dat_i),
    .wb_dat_o    (wb_dat_o),
    .wb_ack_o    (wb_ack_o),
    .mem_wr_o    (mem_wr_o),
    .mem_wdata_o (mem_wdata_o),
    .io_wr_o     (io_wr_o),
    .io_wdata_o  (io_wdata_o),
    .work_o      (work_o),
    .flags_o     (flags_o)
  );

  always #10 clk_i = ~clk_i;

  // ----------------------------------------------------------------------
  // Closing and timeout
  // ----------------------------------------------------------------------
  task automatic end_sim();
    begin
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // The whole run needs well under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  // Strobes are captured one edge after the commit edge, where they stand
  task automatic bus(input logic w, input logic [7:0] adr, input logic [7:0] d, input logic [3:0] sel);
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= {24'h00_0000, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
        @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
      st_mem = mem_wr_o;
      st_io  = io_wr_o;
      st_wd  = mem_wdata_o;
      st_iod = io_wdata_o;
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    bus(1'b1, adr, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] adr);
    bus(1'b0, adr, 8'h00, 4'hF);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i])
    begin
      wr(`LOU_OFF_WORK, rows[i].work);
      wr(`LOU_OFF_FLAGS, {4'h0, rows[i].flg});
      wr(`LOU_OFF_OPND, rows[i].opnd);
      wr(`LOU_OFF_CMD, {4'h0, rows[i].op});
      k = (rows[i].op == 4'h7) ? 2'd2 : (rows[i].op inside {4'h2, 4'h5, 4'h9, 4'hB, 4'hD}) ? 2'd1 : 2'd0;
      exp_w = (k == 2'd0) ? rows[i].res : rows[i].work;
      exp_f = (k == 2'd2) ? rows[i].flg : {rows[i].flg[3:1], rows[i].res == 8'h00};
      `CHK(work_o, exp_w)
      `CHK(flags_o, exp_f)
      `CHK({st_io, st_mem}, {k == 2'd2, k == 2'd1})
      if (k == 2'd1)
        `CHK(st_wd, rows[i].res)
      if (k == 2'd2)
        `CHK(st_iod, rows[i].res)
      rd(`LOU_OFF_RESULT);
      `CHK(q, {22'h0_0000, k == 2'd2, k == 2'd1, rows[i].res})
      $display("row %0d done", i);
    end

    // Undefined codes and a write without its byte lane leave state alone
    wr(`LOU_OFF_WORK, 8'h5A);
    wr(`LOU_OFF_FLAGS, 8'h03);
    wr(`LOU_OFF_CMD, 8'h0E);
    wr(`LOU_OFF_CMD, 8'h0F);
    `CHK({st_io, st_mem, flags_o, work_o}, {2'b00, 4'h3, 8'h5A})
    bus(1'b1, `LOU_OFF_WORK, 8'hFF, 4'hE);
    `CHK(work_o, 8'h5A)
    rd(`LOU_OFF_CMD);
    `CHK(q, 32'h0000_000D)
    $display("refused writes done");

    // Back-to-back negations return the starting value
    wr(`LOU_OFF_WORK, 8'h38);
    wr(`LOU_OFF_CMD, 8'h0C);
    `CHK(work_o, 8'hC8)
    wr(`LOU_OFF_CMD, 8'h0C);
    `CHK({flags_o, work_o}, {4'h2, 8'h38})
    $display("chained ops done");

    // Unmapped place reads zero, result register ignores writes
    rd(8'h14);
    `CHK(q, 32'h0000_0000)
    wr(`LOU_OFF_RESULT, 8'hFF);
    rd(`LOU_OFF_RESULT);
    `CHK(q, 32'h0000_0038)
    $display("address map done");

    // Reset in mid-run clears every register
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK({wb_ack_o, mem_wr_o, io_wr_o, flags_o, work_o}, 15'h000)
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (offs[i])
    begin
      rd(offs[i]);
      `CHK(q, 32'h0000_0000)
    end
    $display("reset done");
    end_sim();
  end

endmodule

`undef CHK
`default_nettype wire
